/* shared/macrocell_pkg.sv */
// constants, types and sizing functions for the macrocell array
package macrocell_pkg;

  // ---------------------------------------------------------------
  // variants
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    VARIANT_BASE,
    VARIANT_REDUCED,
    VARIANT_EXTENDED
  } variant_type;

  // ---------------------------------------------------------------
  // array sizing (largest value over all variants)
  // ---------------------------------------------------------------
  localparam int NUM_IN_MAX = 14;
  localparam int NUM_CELL_MAX = 12;
  localparam int ARRAY_IN = NUM_IN_MAX + NUM_CELL_MAX;
  localparam int ROW_W = 2 * ARRAY_IN;
  localparam int NUM_ROWS = 122;
  localparam int MAX_TERMS = 16;
  localparam int ROW_CLEAR = 0;
  localparam int ROW_SET = 1;
  localparam int ROW_FIRST_CELL = 2;
  localparam int ROW_HI_W = ROW_W - 32;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_FUSE_END = 12'h3D0;
  localparam logic [11:0] ADDR_MODE = 12'h400;
  localparam logic [11:0] ADDR_POLARITY = 12'h404;
  localparam logic [11:0] ADDR_OE = 12'h408;
  localparam logic [11:0] ADDR_OUT_STATE = 12'h40C;
  localparam logic [11:0] ADDR_IN_STATE = 12'h410;
  localparam int FUSE_ROW_LSB = 3;
  localparam int FUSE_HALF_BIT = 2;
  localparam logic [ROW_W-1:0] FUSE_RESET = {ROW_W{1'b1}};
  localparam logic [NUM_CELL_MAX-1:0] MODE_RESET = 12'h000;
  localparam logic [NUM_CELL_MAX-1:0] POLARITY_RESET = 12'h000;
  localparam logic [NUM_CELL_MAX-1:0] OE_RESET = 12'h000;

  // ---------------------------------------------------------------
  // carrier for one macrocell's configuration
  // ---------------------------------------------------------------
  typedef struct packed {
    logic registered;
    logic inverted;
  } cell_ctrl_type;

  // ---------------------------------------------------------------
  // sizing functions
  // ---------------------------------------------------------------
  function automatic int num_inputs(variant_type v);
    case (v)
      VARIANT_REDUCED: num_inputs = 8;
      VARIANT_EXTENDED: num_inputs = 14;
      default: num_inputs = 12;
    endcase
  endfunction

  function automatic int num_cells(variant_type v);
    num_cells = (v == VARIANT_EXTENDED) ? 12 : 10;
  endfunction

  function automatic int cell_terms(variant_type v, int i);
    case (v)
      VARIANT_REDUCED: cell_terms = (i < 8) ? 8 : 10;
      VARIANT_EXTENDED: cell_terms = (i < 8) ? 8 : ((i < 10) ? 10 : 12);
      default: cell_terms = 8 + 2 * (i / 2);
    endcase
  endfunction

  function automatic int cell_first_row(variant_type v, int i);
    int acc;
    acc = ROW_FIRST_CELL;
    for (int k = 0; k < i; k++) begin
      acc = acc + cell_terms(v, k);
    end
    cell_first_row = acc;
  endfunction

endpackage

/* design/fuse_row_memory.sv */
// product term fuse rows with a write port and a registered read port
module fuse_row_memory (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic wr_en,
  input wire logic [6:0] wr_row,
  input wire logic wr_hi,
  input wire logic [31:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic [6:0] rd_row,
  input wire logic rd_hi,
  output logic [31:0] rd_data_ff,
  // all rows to the array
  output logic [macrocell_pkg::ROW_W-1:0] rows_ff [macrocell_pkg::NUM_ROWS]
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // erased rows hold every literal and its complement, so terms are false
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < macrocell_pkg::NUM_ROWS; r++) begin
        rows_ff[r] <= macrocell_pkg::FUSE_RESET;
      end
    end else if (wr_en) begin
      if (wr_hi) begin
        rows_ff[wr_row][macrocell_pkg::ROW_W-1:32] <=
          wr_data[macrocell_pkg::ROW_HI_W-1:0];
      end else begin
        rows_ff[wr_row][31:0] <= wr_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // read
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      if (rd_hi) begin
        rd_data_ff <= {{(32 - macrocell_pkg::ROW_HI_W){1'b0}},
                       rows_ff[rd_row][macrocell_pkg::ROW_W-1:32]};
      end else begin
        rd_data_ff <= rows_ff[rd_row][31:0];
      end
    end
  end

endmodule

/* design/output_macrocell.sv */
// one output macrocell: term sum, storage flip-flop, polarity, pin drive
module output_macrocell #(
  parameter int NTERMS = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration
  input wire macrocell_pkg::cell_ctrl_type ctrl,
  // array side
  input wire logic [NTERMS-1:0] terms,
  input wire logic capture,
  input wire logic shared_async_clear_term,
  input wire logic shared_sync_set_term,
  // results
  output logic q_ff,
  output logic pin_out_ff
);

  logic sop;
  logic value;

  assign sop = |terms;

  // ---------------------------------------------------------------
  // storage flip-flop
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= 1'b0;
    end else if (ctrl.registered && shared_async_clear_term) begin
      q_ff <= 1'b0;
    end else if (ctrl.registered && capture) begin
      q_ff <= shared_sync_set_term ? 1'b1 : sop;
    end
  end

  // ---------------------------------------------------------------
  // output path
  // ---------------------------------------------------------------
  // clear is also applied on the path so the pin clears on the same pclk edge as q_ff
  always_comb begin
    if (ctrl.registered) begin
      value = shared_async_clear_term ? 1'b0 : q_ff;
    end else begin
      value = sop;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_ff <= 1'b0;
    end else begin
      pin_out_ff <= value ^ ctrl.inverted;
    end
  end

endmodule

/* design/registered_macrocell_array.sv */
// sum-of-products array with output macrocells and an apb register port
module registered_macrocell_array #(
  parameter macrocell_pkg::variant_type VARIANT =
    macrocell_pkg::VARIANT_BASE
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // dedicated pins
  input wire logic dclk_pin,
  input wire logic [macrocell_pkg::NUM_IN_MAX-1:0] din_pin,
  // two-way macrocell pins
  input wire logic [macrocell_pkg::NUM_CELL_MAX-1:0] io_in,
  output logic [macrocell_pkg::NUM_CELL_MAX-1:0] io_out,
  output logic [macrocell_pkg::NUM_CELL_MAX-1:0] io_oe
);

  // ---------------------------------------------------------------
  // sizing
  // ---------------------------------------------------------------
  localparam int NIN = macrocell_pkg::num_inputs(VARIANT);
  localparam int NCELL = macrocell_pkg::num_cells(VARIANT);
  localparam int NC = macrocell_pkg::NUM_CELL_MAX;
  localparam int NI = macrocell_pkg::NUM_IN_MAX;
  localparam int AW = macrocell_pkg::ARRAY_IN;
  localparam int NR = macrocell_pkg::NUM_ROWS;
  localparam logic [NC-1:0] CELL_MASK = NC'((1 << NCELL) - 1);
  localparam logic [NI-1:0] IN_MASK = NI'((1 << NIN) - 1);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [NI-1:0] din_meta_ff;
  logic [NI-1:0] din_sync_ff;
  logic [NC-1:0] io_meta_ff;
  logic [NC-1:0] io_sync_ff;
  logic dclk_meta_ff;
  logic dclk_sync_ff;
  logic dclk_prev_ff;
  logic capture;
  logic [NC-1:0] mode_ff;
  logic [NC-1:0] polarity_ff;
  logic [NC-1:0] oe_ff;
  logic [NC-1:0] q_bus;
  logic [NC-1:0] pin_bus;
  logic [NC-1:0] feedback;
  logic [AW-1:0] array_in;
  logic [AW-1:0] used_mask;
  logic [2*AW-1:0] literals;
  logic [macrocell_pkg::ROW_W-1:0] rows [NR];
  logic [NR-1:0] term;
  logic setup_phase;
  logic access_wr;
  logic in_fuse;
  logic [6:0] fuse_row;
  logic fuse_hi;
  logic mapped;
  logic [31:0] mem_rdata;
  logic [31:0] reg_rdata_ff;
  logic [31:0] nxt_reg_rdata;
  logic sel_mem_ff;
  logic err_ff;
  logic wr_mode;
  logic wr_polarity;
  logic wr_oe;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // pins are asynchronous to pclk; two stages before any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_meta_ff <= '0;
      din_sync_ff <= '0;
    end else begin
      din_meta_ff <= din_pin;
      din_sync_ff <= din_meta_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_meta_ff <= '0;
      io_sync_ff <= '0;
    end else begin
      io_meta_ff <= io_in;
      io_sync_ff <= io_meta_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dclk_meta_ff <= 1'b0;
      dclk_sync_ff <= 1'b0;
      dclk_prev_ff <= 1'b0;
    end else begin
      dclk_meta_ff <= dclk_pin;
      dclk_sync_ff <= dclk_meta_ff;
      dclk_prev_ff <= dclk_sync_ff;
    end
  end

  // dedicated clock must stay below half the pclk rate to be seen
  assign capture = dclk_sync_ff & ~dclk_prev_ff;

  // ---------------------------------------------------------------
  // and array
  // ---------------------------------------------------------------
  // registered cells feed back their flop, others their pin
  assign feedback = (mode_ff & q_bus) | (~mode_ff & io_sync_ff);
  assign array_in = {feedback & CELL_MASK, din_sync_ff & IN_MASK};
  assign used_mask = {CELL_MASK, IN_MASK};

  // unused columns read as true so they never spoil a term
  always_comb begin
    literals = '0;
    for (int k = 0; k < AW; k++) begin
      literals[2*k] = array_in[k] | ~used_mask[k];
      literals[2*k+1] = ~array_in[k] | ~used_mask[k];
    end
  end

  // a set fuse bit connects that literal into the term
  genvar r;
  generate
    for (r = 0; r < NR; r++) begin : g_term
      assign term[r] = &(~rows[r] | literals);
    end
  endgenerate

  // ---------------------------------------------------------------
  // macrocells
  // ---------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : g_cell
      if (c < NCELL) begin : g_used
        localparam int FIRST = macrocell_pkg::cell_first_row(VARIANT, c);
        localparam int NT = macrocell_pkg::cell_terms(VARIANT, c);
        macrocell_pkg::cell_ctrl_type ctrl;
        assign ctrl.registered = mode_ff[c];
        assign ctrl.inverted = polarity_ff[c];
        output_macrocell #(
          .NTERMS(NT)
        ) u_cell (
          .pclk(pclk),
          .presetn(presetn),
          .ctrl(ctrl),
          .terms(term[FIRST +: NT]),
          .capture(capture),
          .shared_async_clear_term(term[macrocell_pkg::ROW_CLEAR]),
          .shared_sync_set_term(term[macrocell_pkg::ROW_SET]),
          .q_ff(q_bus[c]),
          .pin_out_ff(pin_bus[c])
        );
      end else begin : g_absent
        assign q_bus[c] = 1'b0;
        assign pin_bus[c] = 1'b0;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // missing cells stay released so a small variant never fights the board
  assign io_out = pin_bus;
  assign io_oe = oe_ff & CELL_MASK;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign setup_phase = psel & ~penable;
  assign access_wr = psel & penable & pwrite & ~err_ff;
  assign in_fuse = paddr < macrocell_pkg::ADDR_FUSE_END;
  assign fuse_row = paddr[macrocell_pkg::FUSE_ROW_LSB +: 7];
  assign fuse_hi = paddr[macrocell_pkg::FUSE_HALF_BIT];

  // word aligned and on a fuse row or a control register, else refused
  always_comb begin
    mapped = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      mapped = in_fuse ||
               paddr == macrocell_pkg::ADDR_MODE ||
               paddr == macrocell_pkg::ADDR_POLARITY ||
               paddr == macrocell_pkg::ADDR_OE ||
               paddr == macrocell_pkg::ADDR_OUT_STATE ||
               paddr == macrocell_pkg::ADDR_IN_STATE;
    end
  end

  // decode is caught in setup, so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ff <= 1'b0;
      sel_mem_ff <= 1'b0;
    end else if (setup_phase) begin
      err_ff <= ~mapped;
      sel_mem_ff <= in_fuse;
    end
  end

  fuse_row_memory u_fuses (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(access_wr & in_fuse),
    .wr_row(fuse_row),
    .wr_hi(fuse_hi),
    .wr_data(pwdata),
    .rd_en(setup_phase & ~pwrite & in_fuse),
    .rd_row(fuse_row),
    .rd_hi(fuse_hi),
    .rd_data_ff(mem_rdata),
    .rows_ff(rows)
  );

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // strobes come from the access phase only, after the decode check
  assign wr_mode = access_wr && paddr == macrocell_pkg::ADDR_MODE;
  assign wr_polarity = access_wr && paddr == macrocell_pkg::ADDR_POLARITY;
  assign wr_oe = access_wr && paddr == macrocell_pkg::ADDR_OE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= macrocell_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_ff <= pwdata[NC-1:0] & CELL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polarity_ff <= macrocell_pkg::POLARITY_RESET;
    end else if (wr_polarity) begin
      polarity_ff <= pwdata[NC-1:0] & CELL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_ff <= macrocell_pkg::OE_RESET;
    end else if (wr_oe) begin
      oe_ff <= pwdata[NC-1:0] & CELL_MASK;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    nxt_reg_rdata = 32'h0000_0000;
    case (paddr)
      macrocell_pkg::ADDR_MODE: nxt_reg_rdata[NC-1:0] = mode_ff;
      macrocell_pkg::ADDR_POLARITY: nxt_reg_rdata[NC-1:0] = polarity_ff;
      macrocell_pkg::ADDR_OE: nxt_reg_rdata[NC-1:0] = oe_ff;
      macrocell_pkg::ADDR_OUT_STATE: nxt_reg_rdata[NC-1:0] = pin_bus;
      macrocell_pkg::ADDR_IN_STATE: nxt_reg_rdata[NI-1:0] = din_sync_ff;
      default: nxt_reg_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (setup_phase) begin
      reg_rdata_ff <= nxt_reg_rdata;
    end
  end

  // refused accesses read zero whatever the memory last fetched
  always_comb begin
    if (err_ff) begin
      prdata = 32'h0000_0000;
    end else if (sel_mem_ff) begin
      prdata = mem_rdata;
    end else begin
      prdata = reg_rdata_ff;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_ff;

endmodule

/* test/board_model.sv */
// board side of the two-way pins: pull-ups on every released pin
module board_model (
  // pins
  input wire logic [11:0] io_out,
  input wire logic [11:0] io_oe,
  output logic [11:0] io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin floats up, so it never echoes the last driven value
  assign io_in = (io_oe & io_out) | ~io_oe;
endmodule

/* test/macrocell_array_props.sv */
// port-level assertions for the macrocell array
module macrocell_array_props #(
  parameter macrocell_pkg::variant_type VARIANT =
    macrocell_pkg::VARIANT_BASE
) (
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic dclk_pin,
  input wire logic [13:0] din_pin,
  input wire logic [11:0] io_in,
  input wire logic [11:0] io_out,
  input wire logic [11:0] io_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCELL =
    (VARIANT == macrocell_pkg::VARIANT_EXTENDED) ? 12 : 10;
  localparam logic [11:0] MASK = 12'hFFF >> (12 - NCELL);
  logic wr_acc;
  logic [11:0] mode_ff;
  logic [11:0] pol_ff;
  logic [11:0] oe_ff;
  logic [13:0] din_ff;
  logic [11:0] io_ff;
  logic [3:0] quiet_ff;
  logic [3:0] nxt_quiet;
  assign wr_acc = psel && penable && pwrite;
  // quiet means no write, dclk low, pins unchanged; saturates at 15
  assign nxt_quiet = (wr_acc || dclk_pin || din_pin != din_ff ||
    io_in != io_ff) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hF};
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // shadow of control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= macrocell_pkg::MODE_RESET;
      pol_ff <= macrocell_pkg::POLARITY_RESET;
      oe_ff <= macrocell_pkg::OE_RESET;
    end else if (wr_acc) begin
      if (paddr == macrocell_pkg::ADDR_MODE) mode_ff <= pwdata[11:0] & MASK;
      if (paddr == macrocell_pkg::ADDR_POLARITY) pol_ff <= pwdata[11:0] & MASK;
      if (paddr == macrocell_pkg::ADDR_OE) oe_ff <= pwdata[11:0] & MASK;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_ff <= 14'h0000;
      io_ff <= 12'h000;
      quiet_ff <= 4'h0;
    end else begin
      din_ff <= din_pin;
      io_ff <= io_in;
      quiet_ff <= nxt_quiet;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_write(logic [11:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence s_read(logic [11:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  property p_pol_flip;
    logic [11:0] old;
    logic [11:0] diff;
    (s_write(macrocell_pkg::ADDR_POLARITY) ##0 (quiet_ff >= 4'h8,
      old = io_out, diff = (pwdata[11:0] ^ pol_ff) & MASK))
      |-> ##2 io_out == (old ^ diff);
  endproperty
  a_unused_out_low: assert property (
    (io_out & ~MASK) == 12'h000) else $error("missing cell drives io_out");
  a_oe_matches: assert property (
    io_oe == oe_ff) else $error("io_oe differs from last oe write");
  a_quiet_stable: assert property (
    quiet_ff >= 4'h8 |-> $stable(io_out))
    else $error("io_out moved with no clock or input change");
  a_polarity_flip: assert property (
    p_pol_flip) else $error("polarity write did not invert io_out");
  a_read_mode: assert property (
    s_read(macrocell_pkg::ADDR_MODE) |-> prdata == {20'h00000, mode_ff})
    else $error("mode readback wrong");
  a_read_polarity: assert property (
    s_read(macrocell_pkg::ADDR_POLARITY) |-> prdata == {20'h00000, pol_ff})
    else $error("polarity readback wrong");
  a_misaligned_err: assert property (
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  a_release_idle: assert property (
    $rose(presetn) |-> io_out == 12'h000 && io_oe == 12'h000)
    else $error("pins active right after reset");
endmodule

bind registered_macrocell_array macrocell_array_props #(
  .VARIANT(VARIANT)
) u_props (.*);

/* test/tb.sv */
// self-checking bench for the macrocell array, all three variants
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LAST_ROW [10] = '{9, 17, 27, 37, 49, 61, 75, 89, 105, 121};
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dclk_pin;
  logic [13:0] din_pin;
  logic [11:0] io_in;
  logic [11:0] io_out;
  logic [11:0] io_oe;
  logic [11:0] io_in_r;
  logic [11:0] io_out_r;
  logic [11:0] io_oe_r;
  logic [11:0] io_in_x;
  logic [11:0] io_out_x;
  logic [11:0] io_oe_x;
  logic [31:0] rdat;
  logic rerr;
  int num_errors;
  int num_checks;
  registered_macrocell_array u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dclk_pin(dclk_pin), .din_pin(din_pin), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));
  board_model u_board (.io_out(io_out), .io_oe(io_oe), .io_in(io_in));
  // smaller and larger variants share the bus and the dedicated pins
  registered_macrocell_array #(.VARIANT(macrocell_pkg::VARIANT_REDUCED))
    u_dut_red (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .dclk_pin(dclk_pin),
    .din_pin(din_pin), .io_in(io_in_r), .io_out(io_out_r), .io_oe(io_oe_r));
  board_model u_board_red (.io_out(io_out_r), .io_oe(io_oe_r),
    .io_in(io_in_r));
  registered_macrocell_array #(.VARIANT(macrocell_pkg::VARIANT_EXTENDED))
    u_dut_ext (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .dclk_pin(dclk_pin),
    .din_pin(din_pin), .io_in(io_in_x), .io_out(io_out_x), .io_oe(io_oe_x));
  board_model u_board_ext (.io_out(io_out_x), .io_oe(io_oe_x),
    .io_in(io_in_x));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("prdata", exp, rdat);
  endtask
  task automatic row(input int r, input logic [31:0] lo);
    apb(1'b1, 12'(8 * r), lo);
    apb(1'b1, 12'(8 * r + 4), 32'h0);
  endtask
  task automatic set_din(input logic [13:0] v);
    din_pin <= v;
    repeat (12) @(posedge pclk);
  endtask
  // dclk stays well above the one-period minimum high and low
  task automatic pulse;
    dclk_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    dclk_pin <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  // sampled at the falling edge, away from the flops' updates
  task automatic out(input logic [11:0] exp);
    @(negedge pclk);
    chk("io_out", 32'(exp), 32'(io_out));
    @(posedge pclk);
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, dclk_pin} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    din_pin = 14'h0000;
    num_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(macrocell_pkg::ADDR_MODE, 32'h0);
    rd(macrocell_pkg::ADDR_POLARITY, 32'h0);
    rd(12'h402, 32'h0);
    chk("pslverr", 32'h1, 32'(rerr));
    $display("test reset done");
    for (int c = 0; c < 10; c++) row(LAST_ROW[c], 32'h1 << (2 * c));
    apb(1'b1, macrocell_pkg::ADDR_OE, 32'hFFF);
    chk("io_oe", 32'h3FF, 32'(io_oe));
    chk("io_oe reduced", 32'h3FF, 32'(io_oe_r));
    chk("io_oe extended", 32'hFFF, 32'(io_oe_x));
    set_din(14'h02AA);
    @(negedge pclk);
    chk("io_out reduced", 32'h092, 32'(io_out_r));
    chk("io_out extended", 32'h492, 32'(io_out_x));
    out(12'h2AA);
    apb(1'b1, macrocell_pkg::ADDR_POLARITY, 32'h155);
    set_din(14'h02AA);
    rd(macrocell_pkg::ADDR_OUT_STATE, 32'h3FF);
    $display("test combinational done");
    apb(1'b1, macrocell_pkg::ADDR_POLARITY, 32'h0);
    row(0, 32'h1 << 22);
    row(1, 32'h1 << 20);
    apb(1'b1, macrocell_pkg::ADDR_MODE, 32'h3FF);
    set_din(14'h0800);
    out(12'h000);
    set_din(14'h02AA);
    out(12'h000);
    pulse;
    out(12'h2AA);
    set_din(14'h0155);
    out(12'h2AA);
    set_din(14'h0555);
    pulse;
    out(12'h3FF);
    set_din(14'h0D55);
    pulse;
    out(12'h000);
    apb(1'b1, macrocell_pkg::ADDR_MODE, 32'h00F);
    set_din(14'h0955);
    out(12'h150);
    apb(1'b1, macrocell_pkg::ADDR_MODE, 32'h3FF);
    apb(1'b1, macrocell_pkg::ADDR_POLARITY, 32'h3FF);
    set_din(14'h0155);
    pulse;
    out(12'h2AA);
    $display("test registered done");
    wrap_up();
  end
  initial begin
    repeat (4000) @(posedge pclk);
    num_errors++;
    $display("FAIL watchdog expected finish seen hang");
    wrap_up();
  end
endmodule
